// ===== rtl/rcs_defines.svh
// register offsets, field positions and reset values of the rtc control bank
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

`define RCS_ADDR_W        5
`define RCS_OFS_CTRL1     5'h00
`define RCS_OFS_CTRL2     5'h01
`define RCS_OFS_CTRL3     5'h02
`define RCS_OFS_ST_MIN    5'h14
`define RCS_OFS_ST_HOUR   5'h15
`define RCS_OFS_ST_DAY    5'h16
`define RCS_OFS_ST_MON    5'h17
`define RCS_OFS_ST_YEAR   5'h18
`define RCS_OFS_AGE       5'h19
`define RCS_OFS_PTR_HI    5'h1a
`define RCS_OFS_PTR_LO    5'h1b
`define RCS_OFS_SRAM_WR   5'h1c
`define RCS_OFS_SRAM_RD   5'h1d

// control one
`define RCS_C1_EXT        7
`define RCS_C1_STOP       5
`define RCS_C1_TMID       4
`define RCS_C1_RESET_OVERRIDE_FACILITY       3
`define RCS_C1_H12        2
`define RCS_C1_MIN_IE     1
`define RCS_C1_SEC_IE     0
// control two
`define RCS_C2_TICK       7
`define RCS_C2_WDOG       6
`define RCS_C2_TGND       5
`define RCS_C2_ALARM      4
`define RCS_C2_CDOWN      3
`define RCS_C2_TAMP_IE    2
`define RCS_C2_ALARM_IE   1
`define RCS_C2_CDOWN_IE   0
// control three
`define RCS_C3_PWR_HI     7
`define RCS_C3_PWR_LO     5
`define RCS_C3_STAMP_EN   4
`define RCS_C3_SWOVR      3
`define RCS_C3_BATLOW     2
`define RCS_C3_SWOVR_IE   1
`define RCS_C3_BATLOW_IE  0

`define RCS_AGE_RESET     4'h8
`define RCS_AGE_MSB       3
`define RCS_AGE_LSB       0
`define RCS_PTR_TOP       0
`define RCS_ZERO8         8'h00

`endif

// ===== rtl/rcs_pkg.sv
// types shared by the rtc control bank
package rcs_pkg;

	// register access request from the serial front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} rcs_req_t;

	// events raised by the timekeeping and power engines
	typedef struct packed {
		logic tick;
		logic watchdog;
		logic tamper_mid;
		logic tamper_gnd;
		logic alarm;
		logic countdown;
		logic switchover;
		logic battery_low;
	} rcs_evt_t;

	// captured time for the stamp registers
	typedef struct packed {
		logic [6:0] minutes;
		logic [5:0] hours;
		logic [5:0] day;
		logic [4:0] month;
		logic [7:0] year;
	} rcs_stamp_t;

	// settings that steer the rest of the device
	typedef struct packed {
		logic       ext_clock_check_mode;
		logic       clock_stop;
		logic       power_on_reset_override;
		logic       hour_12_mode;
		logic       once_per_60s_irq_en;
		logic       once_per_1s_irq_en;
		logic [2:0] power_management_select;
		logic [3:0] aging_correction;
		logic [8:0] sram_pointer;
	} rcs_cfg_t;

endpackage : rcs_pkg

// ===== rtl/rcs_regs.sv
// rtc control and status register bank
//
// Function
// - unimplemented bit positions always read back as zero
// - bits undefined at power-on are never touched by reset
// - thirteen byte registers; offsets 00h to 02h are control and status
// - control one bit 7 selects normal or external clock test mode
// - stop bit halts timekeeping and clears divider chain; clock out stays
// - tamper mid-level flag sets on mid input, holds until host clears
// - control one bit 3 enables the power-on reset override facility
// - control one bit 2 picks 24-hour (0) or 12-hour (1) counting
// - control one bits 1 and 0 enable minute and second interrupts
// - periodic tick flag sets on minute or second interrupt, holds
// - watchdog flag sets on watchdog event; host writes never clear it
// - tamper ground flag sets on grounded tamper input, holds till clear
// - alarm flag sets on alarm, holds until cleared, clearing drops irq
// - countdown flag sets on countdown interrupt, holds until cleared
// - control two bits 2..0 gate tamper, alarm and countdown interrupts
// - control three bits 7..5 select power management behaviour
// - switchover stamp enable captures a timestamp on each switchover
// - switchover flag sets on switchover, holds until host clears it
// - battery low flag follows battery state; writes cannot clear it
// - control three bits 1 and 0 enable switchover and low battery irq
`timescale 1ns/1ps
`include "rcs_defines.svh"

module rcs_regs #(
	parameter int ADDR_W = `RCS_ADDR_W
) (
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	input  wire rcs_pkg::rcs_req_t   req,
	input  wire rcs_pkg::rcs_evt_t   evt,
	input  wire rcs_pkg::rcs_stamp_t now_time,
	input  wire logic [7:0]          sram_rdata,
	output logic [7:0]               rdata,
	output logic                     irq,
	output logic                     divider_clear,
	output logic                     stamp_taken,
	output logic                     sram_wr_strobe,
	output logic                     sram_rd_strobe,
	output logic [7:0]               sram_wdata,
	output rcs_pkg::rcs_cfg_t        cfg
);
	import rcs_pkg::*;

	// control one fields
	logic       ext_clock_check_mode;
	logic       clock_stop;
	logic       tamper_mid_level_flag;
	logic       power_on_reset_override;
	logic       hour_12_mode;
	logic       once_per_60s_irq_en;
	logic       once_per_1s_irq_en;
	// control two fields
	logic       periodic_tick_flag;
	logic       watchdog_flag;
	logic       tamper_ground_flag;
	logic       alarm_flag;
	logic       countdown_flag;
	logic       tamper_irq_en;
	logic       alarm_irq_en;
	logic       countdown_irq_en;
	// control three fields
	logic [2:0] power_management_select;
	logic       switchover_stamp_en;
	logic       battery_switchover_flag;
	logic       battery_low_flag;
	logic       switchover_irq_en;
	logic       low_battery_irq_en;
	// other registers
	logic [3:0] aging_correction;
	logic       sram_pointer_top_bit;
	logic [7:0] sram_pointer_low;
	rcs_stamp_t stamp;
	logic [7:0] next_rdata;
	logic       next_irq;

	// true when the host writes the given offset
	function automatic logic wr_hit(input rcs_req_t r,
	                                input logic [4:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction : wr_hit

	// flag update: set wins over a write-zero clear
	function automatic logic flag_next(input logic cur, input logic set,
	                                   input logic clr_wr,
	                                   input logic wbit);
		return set | (cur & ~(clr_wr & ~wbit));
	endfunction : flag_next

	// control one settings
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ext_clock_check_mode    <= 1'b0;
			clock_stop              <= 1'b0;
			power_on_reset_override <= 1'b0;
			hour_12_mode            <= 1'b0;
			once_per_60s_irq_en     <= 1'b0;
			once_per_1s_irq_en      <= 1'b0;
		end else if (wr_hit(req, `RCS_OFS_CTRL1)) begin
			// reserved bit 6 is not stored
			ext_clock_check_mode    <= req.wdata[`RCS_C1_EXT];
			clock_stop              <= req.wdata[`RCS_C1_STOP];
			power_on_reset_override <= req.wdata[`RCS_C1_RESET_OVERRIDE_FACILITY];
			hour_12_mode            <= req.wdata[`RCS_C1_H12];
			once_per_60s_irq_en     <= req.wdata[`RCS_C1_MIN_IE];
			once_per_1s_irq_en      <= req.wdata[`RCS_C1_SEC_IE];
		end
	end

	// divider chain held cleared while stopped; clock output path unaffected
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			divider_clear <= 1'b0;
		end else begin
			divider_clear <= wr_hit(req, `RCS_OFS_CTRL1) ?
			                 req.wdata[`RCS_C1_STOP] : clock_stop;
		end
	end

	// tamper mid-level flag in control one
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tamper_mid_level_flag <= 1'b0;
		end else begin
			tamper_mid_level_flag <= flag_next(tamper_mid_level_flag,
				evt.tamper_mid, wr_hit(req, `RCS_OFS_CTRL1),
				req.wdata[`RCS_C1_TMID]);
		end
	end

	// control two event flags; an event in the clearing cycle survives
	// a read-modify-write that writes ones leaves new events alone
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			periodic_tick_flag <= 1'b0;
			tamper_ground_flag <= 1'b0;
			alarm_flag         <= 1'b0;
			countdown_flag     <= 1'b0;
		end else begin
			periodic_tick_flag <= flag_next(periodic_tick_flag,
				evt.tick & (once_per_60s_irq_en | once_per_1s_irq_en),
				wr_hit(req, `RCS_OFS_CTRL2),
				req.wdata[`RCS_C2_TICK]);
			tamper_ground_flag <= flag_next(tamper_ground_flag,
				evt.tamper_gnd, wr_hit(req, `RCS_OFS_CTRL2),
				req.wdata[`RCS_C2_TGND]);
			alarm_flag <= flag_next(alarm_flag, evt.alarm,
				wr_hit(req, `RCS_OFS_CTRL2),
				req.wdata[`RCS_C2_ALARM]);
			countdown_flag <= flag_next(countdown_flag, evt.countdown,
				wr_hit(req, `RCS_OFS_CTRL2),
				req.wdata[`RCS_C2_CDOWN]);
		end
	end

	// switchover flag in control three
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			battery_switchover_flag <= 1'b0;
		end else begin
			battery_switchover_flag <= flag_next(battery_switchover_flag,
				evt.switchover, wr_hit(req, `RCS_OFS_CTRL3),
				req.wdata[`RCS_C3_SWOVR]);
		end
	end

	// watchdog flag: only reset clears it, host writes never reach it
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			watchdog_flag <= 1'b0;
		else
			watchdog_flag <= watchdog_flag | evt.watchdog;
	end

	// battery low tracks its detector; a write cannot hide a low battery
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			battery_low_flag <= 1'b0;
		else
			battery_low_flag <= evt.battery_low;
	end

	// control two interrupt enables
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tamper_irq_en    <= 1'b0;
			alarm_irq_en     <= 1'b0;
			countdown_irq_en <= 1'b0;
		end else if (wr_hit(req, `RCS_OFS_CTRL2)) begin
			tamper_irq_en    <= req.wdata[`RCS_C2_TAMP_IE];
			alarm_irq_en     <= req.wdata[`RCS_C2_ALARM_IE];
			countdown_irq_en <= req.wdata[`RCS_C2_CDOWN_IE];
		end
	end

	// control three power selection and enables
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			power_management_select <= 3'h0;
			switchover_stamp_en     <= 1'b0;
			switchover_irq_en       <= 1'b0;
			low_battery_irq_en      <= 1'b0;
		end else if (wr_hit(req, `RCS_OFS_CTRL3)) begin
			power_management_select <=
				req.wdata[`RCS_C3_PWR_HI:`RCS_C3_PWR_LO];
			switchover_stamp_en <= req.wdata[`RCS_C3_STAMP_EN];
			switchover_irq_en   <= req.wdata[`RCS_C3_SWOVR_IE];
			low_battery_irq_en  <= req.wdata[`RCS_C3_BATLOW_IE];
		end
	end

	// aging trim, default is the no-correction midpoint
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			aging_correction <= `RCS_AGE_RESET;
		else if (wr_hit(req, `RCS_OFS_AGE))
			aging_correction <= req.wdata[`RCS_AGE_MSB:`RCS_AGE_LSB];
	end

	// sram pointer; no auto-increment here, the sram engine owns that
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sram_pointer_top_bit <= 1'b0;
			sram_pointer_low     <= `RCS_ZERO8;
		end else begin
			if (wr_hit(req, `RCS_OFS_PTR_HI))
				sram_pointer_top_bit <= req.wdata[`RCS_PTR_TOP];
			if (wr_hit(req, `RCS_OFS_PTR_LO))
				sram_pointer_low <= req.wdata;
		end
	end

	// timestamp capture; undefined at power-on, so no reset branch
	// a stamp survives reset so a switchover record is not lost
	always_ff @(posedge clk_sys) begin
		if (evt.switchover && switchover_stamp_en)
			stamp <= now_time;
	end

	// capture notice after a timestamp
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			stamp_taken <= 1'b0;
		else
			stamp_taken <= evt.switchover & switchover_stamp_en;
	end

	// sram port strobes, one cycle each
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sram_wr_strobe <= 1'b0;
			sram_rd_strobe <= 1'b0;
		end else begin
			sram_wr_strobe <= wr_hit(req, `RCS_OFS_SRAM_WR);
			sram_rd_strobe <= req.rd && (req.addr == `RCS_OFS_SRAM_RD);
		end
	end

	// write port data is undefined at power-on, so reset leaves it alone
	always_ff @(posedge clk_sys) begin
		if (wr_hit(req, `RCS_OFS_SRAM_WR))
			sram_wdata <= req.wdata;
	end

	// interrupt request from enabled flags and the ungated periodic tick flag
	always_comb begin
		next_irq = (periodic_tick_flag) |
			(tamper_irq_en & (tamper_mid_level_flag | tamper_ground_flag)) |
			(alarm_irq_en & alarm_flag) |
			(countdown_irq_en & countdown_flag) |
			(switchover_irq_en & battery_switchover_flag) |
			(low_battery_irq_en & battery_low_flag);
	end

	// registered so the pin sees a glitch-free level
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= next_irq;
	end

	// read mux; unused positions and unmapped addresses read zero
	// stamp registers read whatever the last capture left
	always_comb begin
		next_rdata = `RCS_ZERO8;
		unique case (req.addr)
			`RCS_OFS_CTRL1:   next_rdata = {ext_clock_check_mode, 1'b0,
				clock_stop, tamper_mid_level_flag, power_on_reset_override,
				hour_12_mode, once_per_60s_irq_en,
				once_per_1s_irq_en};
			`RCS_OFS_CTRL2:   next_rdata = {periodic_tick_flag, watchdog_flag,
				tamper_ground_flag, alarm_flag, countdown_flag,
				tamper_irq_en, alarm_irq_en, countdown_irq_en};
			`RCS_OFS_CTRL3:   next_rdata = {power_management_select,
				switchover_stamp_en, battery_switchover_flag,
				battery_low_flag, switchover_irq_en, low_battery_irq_en};
			`RCS_OFS_ST_MIN:  next_rdata = {1'b0, stamp.minutes};
			`RCS_OFS_ST_HOUR: next_rdata = {2'h0, stamp.hours};
			`RCS_OFS_ST_DAY:  next_rdata = {2'h0, stamp.day};
			`RCS_OFS_ST_MON:  next_rdata = {3'h0, stamp.month};
			`RCS_OFS_ST_YEAR: next_rdata = stamp.year;
			`RCS_OFS_AGE:     next_rdata = {4'h0, aging_correction};
			`RCS_OFS_PTR_HI:  next_rdata = {7'h00, sram_pointer_top_bit};
			`RCS_OFS_PTR_LO:  next_rdata = sram_pointer_low;
			`RCS_OFS_SRAM_RD: next_rdata = sram_rdata;
			default:          next_rdata = `RCS_ZERO8;
		endcase
	end

	// registered read data, one cycle after the address is presented
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			rdata <= `RCS_ZERO8;
		else if (req.rd)
			rdata <= next_rdata;
	end

	// settings presented to the rest of the device
	// a cycle behind the registers, which costs nothing at this rate
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cfg <= '0;
		end else begin
			cfg.ext_clock_check_mode    <= ext_clock_check_mode;
			cfg.clock_stop              <= clock_stop;
			cfg.power_on_reset_override <= power_on_reset_override;
			cfg.hour_12_mode            <= hour_12_mode;
			cfg.once_per_60s_irq_en     <= once_per_60s_irq_en;
			cfg.once_per_1s_irq_en      <= once_per_1s_irq_en;
			cfg.power_management_select <= power_management_select;
			cfg.aging_correction        <= aging_correction;
			cfg.sram_pointer <= {sram_pointer_top_bit, sram_pointer_low};
		end
	end

endmodule : rcs_regs

// ===== tb/rcs_regs_sva.sv
// concurrent checks on the rtc control bank ports
`timescale 1ns/1ps
module rcs_regs_sva
	import rcs_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire rcs_pkg::rcs_req_t req,
	input wire rcs_pkg::rcs_evt_t evt,
	input wire logic [7:0]        rdata,
	input wire logic              irq,
	input wire logic              divider_clear,
	input wire logic              stamp_taken,
	input wire logic              sram_wr_strobe,
	input wire logic              sram_rd_strobe,
	input wire logic [7:0]        sram_wdata,
	input wire rcs_pkg::rcs_cfg_t cfg
);
	logic w0;
	logic r1d;
	logic r_unm;
	// control one writes, sram port reads and reads of holes in the map
	assign w0 = req.wr && req.addr == 5'h00;
	assign r1d = req.rd && req.addr == 5'h1d;
	assign r_unm = req.rd && (req.addr > 5'h1d
		|| (req.addr > 5'h02 && req.addr < 5'h14));
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	a_unmap_rd_zero: assert property (
		r_unm |=> rdata == 8'h00) else $error("hole read not zero");
	a_bit6_rd_zero: assert property (
		req.rd && req.addr == 5'h00 |=> !rdata[6])
		else $error("reserved bit read as one");
	a_sram_wr_pulse: assert property (
		req.wr && req.addr == 5'h1c |=> sram_wr_strobe
		&& sram_wdata == $past(req.wdata)) else $error("sram write lost");
	a_sram_rd_pulse: assert property (
		sram_rd_strobe == $past(r1d)) else $error("sram read strobe wrong");
	a_stop_divider: assert property (
		w0 && req.wdata[5] ##1 !w0 |-> ##[0:1] divider_clear)
		else $error("stop bit did not clear divider");
	a_mode_to_cfg: assert property (
		w0 ##1 !w0 |-> ##1 {cfg.ext_clock_check_mode,
		cfg.power_on_reset_override, cfg.hour_12_mode,
		cfg.once_per_60s_irq_en, cfg.once_per_1s_irq_en}
		== {$past(req.wdata[7], 2), $past(req.wdata[3:0], 2)})
		else $error("mode bits not passed on");
	a_irq_fall_cause: assert property (
		$fell(irq) |-> $past(req.wr, 2) || ($past(evt.battery_low, 3)
		&& !$past(evt.battery_low, 2))) else $error("irq dropped alone");
	a_irq_rise_cause: assert property (
		$rose(irq) |-> $past(req.wr, 2) || $past(evt, 2) != 8'h00)
		else $error("irq raised alone");
	a_age_reset: assert property (
		$rose(resetn) |-> ##[1:2] cfg.aging_correction == 4'h8)
		else $error("aging trim not at default");
	a_stamp_cause: assert property (
		stamp_taken |-> $past(evt.switchover))
		else $error("capture notice without switchover");
endmodule : rcs_regs_sva

bind rcs_regs rcs_regs_sva u_sva (
	.clk_sys(clk_sys), .resetn(resetn), .req(req), .evt(evt),
	.rdata(rdata), .irq(irq), .divider_clear(divider_clear),
	.stamp_taken(stamp_taken),
	.sram_wr_strobe(sram_wr_strobe), .sram_rd_strobe(sram_rd_strobe),
	.sram_wdata(sram_wdata), .cfg(cfg)
);

// ===== tb/rcs_host_model.sv
// host model issuing single-byte register cycles to the rtc bank
`timescale 1ns/1ps
module rcs_host_model
	import rcs_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic [7:0]   rdata,
	output rcs_pkg::rcs_req_t req
);
	initial req = '0;
	// a released bus shows inverted leftovers, so stale fields never match
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = (a == 5'h00) ? (d & 8'hbf) : d;
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, a, v};
		@(posedge clk_sys);
		req <= '{1'b0, 1'b0, ~a, ~v};
	endtask : wr
	// read data is taken one edge after the request was sampled
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		@(posedge clk_sys);
		req <= '{1'b0, 1'b1, a, 8'h5a};
		@(posedge clk_sys);
		req <= '{1'b0, 1'b0, ~a, 8'ha5};
		@(posedge clk_sys);
		#1 q = rdata;
	endtask : rd
endmodule : rcs_host_model

// ===== tb/tb_rcs_regs.sv
// self-checking bench for the rtc control bank
`timescale 1ns/1ps
module tb_rcs_regs;
	import rcs_pkg::*;
	logic       clk_sys, resetn, irq, divider_clear, sram_wr_strobe;
	logic       stamp_taken;
	logic [7:0] sram_rdata, rdata, sram_wdata, q, d;
	logic [7:0] keep [6];
	rcs_req_t   req;
	rcs_evt_t   evt;
	rcs_stamp_t now_time;
	rcs_cfg_t   cfg;
	int         n_mismatch, num_checks;
	int         n_stamp = 0;
	// flag register and bit of each event input, by event bit
	logic [4:0] f_reg [8] = '{5'h02, 5'h02, 5'h01, 5'h01,
		5'h01, 5'h00, 5'h01, 5'h01};
	int         f_bit [8] = '{2, 3, 3, 4, 5, 4, 6, 7};
	// settings registers, readable bits, enables per pass
	logic [4:0] rw_adr [6] = '{5'h00, 5'h01, 5'h02, 5'h19, 5'h1a, 5'h1b};
	logic [7:0] rw_msk [6] = '{8'haf, 8'h07, 8'hf3, 8'h0f, 8'h01, 8'hff};
	logic [7:0] en [2][3] = '{'{8'h03, 8'h07, 8'h03},
		'{8'h03, 8'h00, 8'h00}};

	rcs_regs u_dut (
		.clk_sys(clk_sys), .resetn(resetn), .req(req), .evt(evt),
		.now_time(now_time), .sram_rdata(sram_rdata), .rdata(rdata),
		.irq(irq), .divider_clear(divider_clear),
		.stamp_taken(stamp_taken),
		.sram_wr_strobe(sram_wr_strobe), .sram_rd_strobe(),
		.sram_wdata(sram_wdata), .cfg(cfg)
	);
	rcs_host_model u_host (
		.clk_sys(clk_sys), .rdata(rdata), .req(req)
	);
	// capture notices seen; only enabled switchovers may raise one
	always @(posedge clk_sys)
		if (resetn && stamp_taken === 1'b1)
			n_stamp++;

	// captured time laid out as the five stamp registers
	function automatic logic [7:0] stamp_exp(input int i);
		logic [39:0] s;
		s = {1'b0, now_time.minutes, 2'b0, now_time.hours, 2'b0,
			now_time.day, 3'b0, now_time.month, now_time.year};
		return s[39 - 8 * i -: 8];
	endfunction : stamp_exp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_n
	// one-cycle event, then room for flag and irq to settle
	task automatic pulse(input int e);
		@(posedge clk_sys);
		evt[e] <= 1'b1;
		@(posedge clk_sys);
		evt[e] <= 1'b0;
		wait_n(3);
	endtask : pulse
	task automatic report_and_stop;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// a hang ends the run as a failure
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		resetn = 1'b0;
		evt = '0;
		now_time = '0;
		sram_rdata = 8'h00;
		n_mismatch = 0;
		num_checks = 0;
		d = 8'($urandom(32'h9d52));
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		// reset contents; holes read as zero
		for (int a = 0; a < 32; a++) begin
			if (!(a inside {[20:24], 28, 29})) begin
				u_host.rd(5'(a), q);
				chk(q, (a == 25) ? 8'h08 : 8'h00);
			end
		end
		// all-ones and zero first, then random bytes
		for (int i = 0; i < 8; i++) begin
			for (int r = 0; r < 6; r++) begin
				d = (i < 2) ? {8{i == 0}} : 8'($urandom);
				keep[r] = d;
				u_host.wr(rw_adr[r], d);
				u_host.rd(rw_adr[r], q);
				chk(q, d & rw_msk[r]);
			end
		end
		chk({cfg.power_management_select, cfg.aging_correction,
			cfg.sram_pointer}, {keep[2][7:5], keep[3][3:0],
			keep[4][0], keep[5]});
		// flags latch; irq only through open gates; zero clears
		for (int p = 0; p < 2; p++) begin
			for (int r = 0; r < 3; r++) u_host.wr(5'(r), en[p][r]);
			for (int e = 1; e < 8; e++) begin
				if (e != 6) begin
					pulse(e);
					chk(irq, p == 0 || e == 7);
					d = en[p][f_reg[e]];
					u_host.wr(f_reg[e], d | (8'h01 << f_bit[e]));
					u_host.rd(f_reg[e], q);
					chk(q[f_bit[e]], 1'b1);
					u_host.wr(f_reg[e], d);
					wait_n(2);
					chk(irq, 1'b0);
					u_host.rd(f_reg[e], q);
					chk(q[f_bit[e]], 1'b0);
				end
			end
		end
		u_host.wr(5'h00, 8'h20);
		wait_n(2);
		chk({divider_clear, cfg.clock_stop}, 2'b11);
		// without minute or second enable a tick is ignored
		u_host.wr(5'h00, 8'h00);
		pulse(7);
		u_host.rd(5'h01, q);
		chk(q[7], 1'b0);
		// battery low follows its input and resists writes
		u_host.wr(5'h02, 8'h01);
		@(posedge clk_sys);
		evt.battery_low <= 1'b1;
		wait_n(3);
		chk(irq, 1'b1);
		u_host.wr(5'h02, 8'h01);
		u_host.rd(5'h02, q);
		chk(q[2], 1'b1);
		@(posedge clk_sys);
		evt.battery_low <= 1'b0;
		wait_n(3);
		chk(irq, 1'b0);
		// sram ports pass data straight through
		d = 8'($urandom);
		u_host.wr(5'h1c, d);
		#1;
		chk({sram_wr_strobe, sram_wdata}, {1'b1, d});
		@(posedge clk_sys);
		sram_rdata <= 8'($urandom);
		u_host.rd(5'h1d, q);
		chk(q, sram_rdata);
		// switchover with stamping on captures the time
		@(posedge clk_sys);
		now_time <= rcs_stamp_t'($urandom);
		u_host.wr(5'h02, 8'h10);
		pulse(1);
		for (int i = 0; i < 5; i++) begin
			u_host.rd(5'h14 + 5'(i), q);
			chk(q, stamp_exp(i));
		end
		chk(n_stamp, 1);
		// watchdog flag survives a zero write
		pulse(6);
		u_host.wr(5'h01, 8'h00);
		u_host.rd(5'h01, q);
		chk(q[6], 1'b1);
		// a second reset leaves stamps alone
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		u_host.rd(5'h14, q);
		chk(q, stamp_exp(0));
		u_host.rd(5'h01, q);
		chk(q, 8'h00);
		report_and_stop();
	end
endmodule : tb_rcs_regs
